// >>> rtl/tbcc_device.sv
// Checker end: parses command words, strips offset and padding, checks lengths
//
// Summary of operation
// [R01] Discard trailing padding words; code 10 is 32-byte
// [R02] Codes 00, 01 mean 4- and 16-byte alignment
// [R03] Host writes zero into reserved command bits
// [R04] Bits 20:16 give first valid byte offset
// [R05] Bit 13 marks a packet's opening buffer
// [R06] Bit 12 marks a packet's closing buffer
// [R07] Bits 10:0 give buffer byte count
// [R08] Byte count excludes offset and padding
// [R09] Running total checked against packet length
// [R10] Second word identical within packet, else error
// [R11] Bit 31 raises loaded flag after buffer
// [R12] Opening buffer clears total; closing buffer checks
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tbcc_device (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   tbcc_if.device link,
   output logic [31:0] out_data_o,
   output logic [3:0] out_be_o,
   output logic out_valid_o,
   output logic out_sop_o,
   output logic out_eop_o,
   input wire logic out_ready_i,
   output logic tx_error_flag_o,
   output logic buffer_loaded_flag_o
);
   // ====================
   // Declarations
   tbcc_pkg::tbcc_state_e state_ff;
   tbcc_pkg::tbcc_state_e nxt_state;
   logic [10:0] size_ff;
   logic [4:0] ofs_ff;
   logic first_ff;
   logic last_ff;
   logic ioc_ff;
   logic [31:0] cmdb_ref_ff;
   logic [10:0] pkt_len_ff;
   logic [15:0] total_ff;
   logic [9:0] idx_ff;
   logic [9:0] end_words_ff;
   logic [9:0] data_words_ff;
   logic sop_pend_ff;
   logic fin_ff;
   logic take;
   logic fin;
   logic cmdb_bad;
   logic [10:0] in_size;
   logic [4:0] in_ofs;
   logic [11:0] span;
   logic [11:0] amask;
   logic [11:0] rounded;
   logic [11:0] dw_round;
   logic [9:0] in_end_words;
   logic [9:0] in_data_words;
   logic [3:0] be;
   logic is_data;
   // ====================
   // Link handshake
   // Accept a word whenever the output stage can take it
   assign link.word_ready = !out_valid_o || out_ready_i;
   assign take = link.word_valid && link.word_ready;
   assign link.tx_error_flag = tx_error_flag_o;
   assign link.buffer_loaded_flag = buffer_loaded_flag_o;
   // ====================
   // First command word decode
   // Byte count and start offset of the incoming word
   assign in_size = link.word[tbcc_pkg::SIZE_LO +: tbcc_pkg::SIZE_W]; // [R07]
   assign in_ofs = link.word[tbcc_pkg::OFS_LO +: tbcc_pkg::OFS_W]; // [R04]
   assign span = {7'h00, in_ofs} + {1'b0, in_size};

   // Rounding mask from the end alignment code
   always_comb begin
      case (tbcc_pkg::tbcc_align_e'(link.word[tbcc_pkg::ALIGN_LO +: 2]))
         tbcc_pkg::ALIGN_4: amask = tbcc_pkg::ALIGN4_MASK; // [R02]
         tbcc_pkg::ALIGN_16: amask = tbcc_pkg::ALIGN16_MASK; // [R02]
         tbcc_pkg::ALIGN_32: amask = tbcc_pkg::ALIGN32_MASK; // [R01]
         default: amask = tbcc_pkg::ALIGN4_MASK; // Reserved code taken as 4-byte
      endcase
   end

   // Words holding data, and words up to the aligned end
   assign dw_round = span + tbcc_pkg::ALIGN4_MASK;
   assign in_data_words = dw_round[11:2];
   assign rounded = (span + amask) & ~amask;
   assign in_end_words = rounded[11:2]; // [R01]
   // ====================
   // Buffer completion
   // Last word taken, or an empty buffer after its second word
   always_comb begin
      fin = 1'b0;
      if (take) begin
         if (state_ff == tbcc_pkg::ST_CMD_B) begin
            fin = (end_words_ff == 10'h000);
         end else if (state_ff == tbcc_pkg::ST_BODY) begin
            fin = (idx_ff == end_words_ff - 10'h001);
         end
      end
   end

   // Second word must match the one of the opening buffer
   assign cmdb_bad = take && (state_ff == tbcc_pkg::ST_CMD_B) && !first_ff
                     && (link.word != cmdb_ref_ff); // [R10]
   // ====================
   // Parser state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         tbcc_pkg::ST_CMD_A: begin
            if (take) begin
               nxt_state = tbcc_pkg::ST_CMD_B;
            end
         end
         tbcc_pkg::ST_CMD_B: begin
            if (take) begin
               nxt_state = fin ? tbcc_pkg::ST_CMD_A : tbcc_pkg::ST_BODY;
            end
         end
         tbcc_pkg::ST_BODY: begin
            if (fin) begin
               nxt_state = tbcc_pkg::ST_CMD_A;
            end
         end
         default: nxt_state = tbcc_pkg::ST_CMD_A;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_ff <= tbcc_pkg::ST_CMD_A;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // ====================
   // Captured first command word
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         size_ff <= 11'h000;
         ofs_ff <= 5'h00;
         first_ff <= 1'b0;
         last_ff <= 1'b0;
         ioc_ff <= 1'b0;
         end_words_ff <= 10'h000;
         data_words_ff <= 10'h000;
      end else if (take && state_ff == tbcc_pkg::ST_CMD_A) begin
         size_ff <= in_size; // [R07]
         ofs_ff <= in_ofs; // [R04]
         first_ff <= link.word[tbcc_pkg::FIRST_BIT]; // [R05]
         last_ff <= link.word[tbcc_pkg::LAST_BIT]; // [R06]
         ioc_ff <= link.word[tbcc_pkg::IOC_BIT]; // [R11]
         end_words_ff <= in_end_words; // [R01]
         data_words_ff <= in_data_words;
      end
   end
   // ====================
   // Second word reference and packet length
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cmdb_ref_ff <= 32'h0000_0000;
         pkt_len_ff <= 11'h000;
      end else if (take && state_ff == tbcc_pkg::ST_CMD_B) begin
         if (first_ff) begin
            cmdb_ref_ff <= link.word; // [R10]
         end
         pkt_len_ff <= link.word[tbcc_pkg::SIZE_LO +: tbcc_pkg::PKT_LEN_W];
      end
   end
   // ====================
   // Running per-packet byte total
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         total_ff <= 16'h0000;
      end else if (take && state_ff == tbcc_pkg::ST_CMD_B) begin
         if (first_ff) begin
            total_ff <= {5'h00, size_ff}; // [R12]
         end else begin
            total_ff <= total_ff + {5'h00, size_ff}; // [R09]
         end
      end
   end
   // ====================
   // Word index inside the buffer body
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         idx_ff <= 10'h000;
      end else if (take && state_ff == tbcc_pkg::ST_CMD_B) begin
         idx_ff <= 10'h000;
      end else if (take && state_ff == tbcc_pkg::ST_BODY) begin
         idx_ff <= idx_ff + 10'h001;
      end
   end
   // ====================
   // Data forwarding with offset and padding removed
   tbcc_lane_mask u_lane_mask (
      .idx_i(idx_ff),
      .ofs_i(ofs_ff),
      .size_i(size_ff),
      .be_o(be)
   );

   // Padding words and fully skipped words are dropped
   assign is_data = take && (state_ff == tbcc_pkg::ST_BODY)
                    && (idx_ff < data_words_ff) && (be != 4'h0); // [R04]

   // Packet start pending until the first forwarded word
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sop_pend_ff <= 1'b0;
      end else if (take && state_ff == tbcc_pkg::ST_CMD_B) begin
         sop_pend_ff <= first_ff; // [R05]
      end else if (is_data) begin
         sop_pend_ff <= 1'b0;
      end
   end

   // Output stage, held until the sink takes it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= 32'h0000_0000;
         out_be_o <= 4'h0;
         out_sop_o <= 1'b0;
         out_eop_o <= 1'b0;
      end else if (is_data) begin
         out_valid_o <= 1'b1;
         out_data_o <= link.word;
         out_be_o <= be; // [R08]
         out_sop_o <= sop_pend_ff;
         out_eop_o <= last_ff && (idx_ff == data_words_ff - 10'h001); // [R06]
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
   // ====================
   // Completion flags
   // Check runs one cycle after the buffer's last word
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         fin_ff <= 1'b0;
      end else begin
         fin_ff <= fin;
      end
   end

   // Loaded pulse when the buffer asked for it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         buffer_loaded_flag_o <= 1'b0;
      end else begin
         buffer_loaded_flag_o <= fin_ff && ioc_ff; // [R11]
      end
   end

   // Error pulse on second word mismatch or length mismatch
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tx_error_flag_o <= 1'b0;
      end else begin
         tx_error_flag_o <= cmdb_bad // [R10]
            || (fin_ff && last_ff && (total_ff != {5'h00, pkt_len_ff})); // [R09] [R12]
      end
   end
endmodule

// >>> rtl/tbcc_host.sv
// Controller end: AXI4-Lite registers that feed command and data words
`timescale 1ns/1ps
module tbcc_host (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   tbcc_if.host link,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_o
);
   // ====================
   // Declarations
   logic [3:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic word_valid_ff;
   logic [31:0] word_ff;
   logic [1:0] mask_ff;
   logic [1:0] stat_ff;
   logic [1:0] nxt_stat;
   logic both_held;
   logic go;
   logic is_link_reg;
   logic rd_take;
   logic stat_rd;

   assign link.word_valid = word_valid_ff;
   assign link.word = word_ff;

   // Both halves of a write are held and nothing is in flight
   assign both_held = !s_axi_awready && !s_axi_wready;
   assign go = both_held && !s_axi_bvalid && !word_valid_ff;
   assign is_link_reg = (waddr_ff == tbcc_pkg::REG_CMDA) || (waddr_ff == tbcc_pkg::REG_WORD);

   // ====================
   // Write address and data capture, either order
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         waddr_ff <= 4'h0;
         wdata_ff <= 32'h0000_0000;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            waddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_ff <= s_axi_wdata;
         end
      end
   end

   // ====================
   // Link word out; the response waits until the checker takes it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         word_valid_ff <= 1'b0;
         word_ff <= 32'h0000_0000;
      end else if (go && is_link_reg) begin
         word_valid_ff <= 1'b1;
         if (waddr_ff == tbcc_pkg::REG_CMDA) begin
            word_ff <= wdata_ff & ~tbcc_pkg::CMDA_RSVD_MASK; // [R03]
         end else begin
            word_ff <= wdata_ff;
         end
      end else if (word_valid_ff && link.word_ready) begin
         word_valid_ff <= 1'b0;
      end
   end

   // Write response and mask register
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tbcc_pkg::RESP_OKAY;
         mask_ff <= tbcc_pkg::MASK_RST;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (word_valid_ff && link.word_ready) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= tbcc_pkg::RESP_OKAY;
      end else if (go && !is_link_reg) begin
         s_axi_bvalid <= 1'b1;
         if (waddr_ff == tbcc_pkg::REG_MASK) begin
            s_axi_bresp <= tbcc_pkg::RESP_OKAY;
            mask_ff <= wdata_ff[1:0];
         end else begin
            s_axi_bresp <= tbcc_pkg::RESP_SLVERR;
         end
      end
   end

   // ====================
   // Read channel
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign stat_rd = rd_take && (s_axi_araddr == tbcc_pkg::REG_STATUS);

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= tbcc_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= tbcc_pkg::RESP_OKAY;
         case (s_axi_araddr)
            tbcc_pkg::REG_STATUS: s_axi_rdata <= {29'h0, word_valid_ff, stat_ff};
            tbcc_pkg::REG_MASK: s_axi_rdata <= {30'h0, mask_ff};
            tbcc_pkg::REG_CMDA, tbcc_pkg::REG_WORD: s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= tbcc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ====================
   // Sticky status, read clears, a new event wins over the clear
   always_comb begin
      nxt_stat = stat_rd ? 2'h0 : stat_ff;
      nxt_stat[tbcc_pkg::STAT_ERR] = nxt_stat[tbcc_pkg::STAT_ERR] | link.tx_error_flag;
      nxt_stat[tbcc_pkg::STAT_DONE] = nxt_stat[tbcc_pkg::STAT_DONE] | link.buffer_loaded_flag;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         stat_ff <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_o <= |(nxt_stat & mask_ff);
      end
   end
endmodule

// >>> rtl/tbcc_if.sv
// Word link between the command-writing controller and the checker
`timescale 1ns/1ps
interface tbcc_if;
   logic [31:0] word;
   logic word_valid;
   logic word_ready;
   logic tx_error_flag;
   logic buffer_loaded_flag;

   modport host (
      output word,
      output word_valid,
      input word_ready,
      input tx_error_flag,
      input buffer_loaded_flag
   );
   modport device (
      input word,
      input word_valid,
      output word_ready,
      output tx_error_flag,
      output buffer_loaded_flag
   );
endinterface

// >>> rtl/tbcc_lane_mask.sv
// Byte lane enables of one buffer word from start offset and byte count
`timescale 1ns/1ps
module tbcc_lane_mask (
   input wire logic [9:0] idx_i,
   input wire logic [4:0] ofs_i,
   input wire logic [10:0] size_i,
   output logic [3:0] be_o
);
   logic [11:0] lo;
   logic [11:0] hi;

   // Valid byte window [offset, offset + size)
   assign lo = {7'h00, ofs_i};
   assign hi = lo + {1'b0, size_i};

   // One compare pair per lane
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign be_o[g] = ({idx_i, 2'(g)} >= lo) && ({idx_i, 2'(g)} < hi);
   end
endmodule

// >>> rtl/tbcc_pkg.sv
// Constants shared by both ends of the transmit buffer command checker
package tbcc_pkg;
   // ====================
   // First command word field positions
   localparam int unsigned IOC_BIT = 31;
   localparam int unsigned ALIGN_LO = 24;
   localparam int unsigned OFS_LO = 16;
   localparam int unsigned FIRST_BIT = 13;
   localparam int unsigned LAST_BIT = 12;
   localparam int unsigned SIZE_LO = 0;
   localparam int unsigned SIZE_W = 11;
   localparam int unsigned OFS_W = 5;
   localparam int unsigned PKT_LEN_W = 11;
   // Reserved bits 30:26, 23:21, 15:14 and 11
   localparam logic [31:0] CMDA_RSVD_MASK = 32'h7ce0_c800;

   // ====================
   // End alignment codes and their rounding masks in bytes
   typedef enum logic [1:0] {
      ALIGN_4 = 2'h0,
      ALIGN_16 = 2'h1,
      ALIGN_32 = 2'h2,
      ALIGN_RSVD = 2'h3
   } tbcc_align_e;
   localparam logic [11:0] ALIGN4_MASK = 12'h003;
   localparam logic [11:0] ALIGN16_MASK = 12'h00f;
   localparam logic [11:0] ALIGN32_MASK = 12'h01f;

   // ====================
   // Device parser states, one-bit steps from ST_CMD_A to ST_CMD_B to ST_BODY, two bits back to ST_CMD_A
   typedef enum logic [1:0] {
      ST_CMD_A = 2'h0,
      ST_CMD_B = 2'h1,
      ST_BODY = 2'h3
   } tbcc_state_e;

   // ====================
   // Controller registers, byte addresses on AXI4-Lite
   localparam logic [3:0] REG_CMDA = 4'h0;
   localparam logic [3:0] REG_WORD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_MASK = 4'hc;
   localparam int unsigned STAT_ERR = 0;
   localparam int unsigned STAT_DONE = 1;
   localparam int unsigned STAT_BUSY = 2;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> testbench/tbcc_monitor.sv
// Concurrent checks on the word link between controller and command checker
`timescale 1ns/1ps
module tbcc_monitor (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [31:0] word,
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic tx_error_flag,
   input wire logic buffer_loaded_flag
);
   // ====================
   // Shadow parser of the link word stream
   localparam logic [1:0] S_CMDA = 2'h0;
   localparam logic [1:0] S_CMDB = 2'h1;
   localparam logic [1:0] S_BODY = 2'h2;
   logic [1:0] st_ff;
   logic [9:0] left_ff;
   logic ioc_ff, first_ff, last_ff;
   logic [31:0] ref_ff;
   logic [11:0] tot_ff;
   logic take, take_a, take_b, fin, fin_ioc, fin_last, len_bad, b_bad;
   logic [11:0] span, amask, nwords;
   logic [31:0] ref_now;

   // Handshake and end-of-buffer decode
   assign take = word_valid & word_ready;
   assign take_a = take & (st_ff == S_CMDA);
   assign take_b = take & (st_ff == S_CMDB);
   assign fin = (take_b & (left_ff == 10'h0)) | (take & (st_ff == S_BODY) & (left_ff == 10'h1));
   assign fin_ioc = fin & ioc_ff;
   assign fin_last = fin & last_ff;
   assign ref_now = (take_b & first_ff) ? word : ref_ff;
   assign len_bad = ({1'b0, ref_now[10:0]} != tot_ff);
   assign b_bad = take_b & !first_ff & (word != ref_ff);

   // Words after the command pair, rounded to the end alignment
   assign span = {7'h0, word[20:16]} + {1'b0, word[10:0]};
   assign amask = (word[25:24] == 2'h1) ? tbcc_pkg::ALIGN16_MASK :
                  (word[25:24] == 2'h2) ? tbcc_pkg::ALIGN32_MASK : tbcc_pkg::ALIGN4_MASK;
   assign nwords = ((span + amask) & ~amask) >> 2;

   // Parser state
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         st_ff <= S_CMDA;
      end else if (take_a) begin
         st_ff <= S_CMDB;
      end else if (take_b) begin
         st_ff <= (left_ff == 10'h0) ? S_CMDA : S_BODY;
      end else if (take & (left_ff == 10'h1)) begin
         st_ff <= S_CMDA;
      end
   end

   // Remaining words and buffer fields
   always_ff @(posedge clock_i) begin
      if (take_a) begin
         left_ff <= nwords[9:0];
         ioc_ff <= word[31];
         first_ff <= word[13];
         last_ff <= word[12];
         tot_ff <= word[13] ? {1'b0, word[10:0]} : tot_ff + {1'b0, word[10:0]};
      end else if (take & (st_ff == S_BODY)) begin
         left_ff <= left_ff - 10'h1;
      end
   end

   // Reference second word of the packet
   always_ff @(posedge clock_i) begin
      if (take_b & first_ff) begin
         ref_ff <= word;
      end
   end

   // ====================
   // Assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   a_rsvd_zero: assert property (take_a |-> (word & tbcc_pkg::CMDA_RSVD_MASK) == 32'h0)
      else $error("reserved command bits not zero");
   a_word_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
      else $error("link word dropped before taken");
   a_loaded_due: assert property (fin_ioc |-> ##2 buffer_loaded_flag)
      else $error("loaded flag missing after buffer");
   a_loaded_cause: assert property (buffer_loaded_flag |-> $past(fin_ioc, 2))
      else $error("loaded flag without finished buffer");
   a_loaded_single: assert property (buffer_loaded_flag |=> !buffer_loaded_flag)
      else $error("loaded flag longer than one cycle");
   a_cmdb_match: assert property (b_bad |-> ##1 tx_error_flag)
      else $error("second word mismatch not flagged");
   a_length_check: assert property (fin_last && len_bad |-> ##2 tx_error_flag)
      else $error("packet length mismatch not flagged");
   a_error_cause: assert property (tx_error_flag |-> $past(b_bad) || $past(fin_last, 2))
      else $error("error flag without cause");

   c_loaded: cover property (fin_ioc ##2 buffer_loaded_flag);
   c_cmdb_bad: cover property (b_bad ##1 tx_error_flag);
   c_len_bad: cover property (fin_last && len_bad ##2 tx_error_flag);
endmodule

// >>> testbench/tx_buffer_command_checker_test.sv
// Self-checking bench for controller and checker joined by the word link
`timescale 1ns/1ps
module tx_buffer_command_checker_test;
   // ====================
   // Signals and model state
   logic clock_i, sys_rst_i, out_ready_i, irq_o;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, out_be_o;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, out_data_o, ref_b;
   logic [1:0] s_axi_bresp, s_axi_rresp, mask;
   logic out_valid_o, out_sop_o, out_eop_o, tx_error_flag_o, buffer_loaded_flag_o;
   logic [63:0] exp_q[$];
   int errors, comparisons, exp_err, exp_ld, n_err, n_ld, tot, i, o, s;

   tbcc_if link();
   tbcc_host u_tbcc_host (.clock_i, .sys_rst_i, .link, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
   tbcc_device u_tbcc_device (.clock_i, .sys_rst_i, .link, .out_data_o, .out_be_o,
      .out_valid_o, .out_sop_o, .out_eop_o, .out_ready_i, .tx_error_flag_o,
      .buffer_loaded_flag_o);
   tbcc_monitor u_tbcc_monitor (.clock_i, .sys_rst_i, .word(link.word),
      .word_valid(link.word_valid), .word_ready(link.word_ready),
      .tx_error_flag(link.tx_error_flag), .buffer_loaded_flag(link.buffer_loaded_flag));

   // Clock at 25 MHz
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // ====================
   // Checks and verdict
   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results;
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ====================
   // AXI4-Lite master
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 3000);
      s_axi_bready <= 1'b0;
      if (n == 3000) begin
         errors++;
         results();
      end
      check("bresp", er, s_axi_bresp);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 3000);
      s_axi_rready <= 1'b0;
      if (n == 3000) begin
         errors++;
         results();
      end
      check("rresp", er, s_axi_rresp);
      check("rdata", ed, s_axi_rdata);
   endtask

   // ====================
   // One buffer: model, words over the bus, flag and status checks
   task automatic run_buf(input int ofs, input int sz, input int al, input int fs,
                          input int ls, input int ioc, input int len, input int tag);
      int m, span, words, j, k, e0;
      logic [31:0] a, b, d;
      logic [3:0] be;
      e0 = exp_err;
      mask = 2'($urandom_range(0, 3));
      axi_wr(tbcc_pkg::REG_MASK, {30'h0, mask}, tbcc_pkg::RESP_OKAY);
      m = (al == 1) ? 16 : (al == 2) ? 32 : 4;
      span = ofs + sz;
      words = (span + m - 1) / m * m / 4;
      a = {ioc[0], 5'h0, al[1:0], 3'h0, ofs[4:0], 2'h0, fs[0], ls[0], 1'h0, sz[10:0]};
      b = {tag[15:0], 5'h0, len[10:0]};
      if (fs != 0) begin
         tot = sz;
         ref_b = b;
      end else begin
         tot += sz;
         if (b != ref_b) exp_err++;
      end
      axi_wr(tbcc_pkg::REG_CMDA, a | tbcc_pkg::CMDA_RSVD_MASK, tbcc_pkg::RESP_OKAY);
      axi_wr(tbcc_pkg::REG_WORD, b, tbcc_pkg::RESP_OKAY);
      for (j = 0; j < words; j++) begin
         d = $urandom;
         for (k = 0; k < 4; k++) be[k] = (4 * j + k >= ofs) && (4 * j + k < span);
         if (be != 4'h0) exp_q.push_back({26'h0, fs != 0 && j == ofs / 4,
                                          ls != 0 && j == (span - 1) / 4, be, d});
         axi_wr(tbcc_pkg::REG_WORD, d, tbcc_pkg::RESP_OKAY);
      end
      if (ls != 0 && tot != ref_b[10:0]) exp_err++;
      if (ioc != 0) exp_ld++;
      repeat (3) @(posedge clock_i);
      check("error pulses", exp_err, n_err);
      check("loaded pulses", exp_ld, n_ld);
      check("irq", |({ioc[0], exp_err != e0} & mask), irq_o);
      axi_rd(tbcc_pkg::REG_STATUS, {30'h0, ioc[0], exp_err != e0}, tbcc_pkg::RESP_OKAY);
   endtask

   // ====================
   // Sink with random stalls, forwarded word compare, pulse counts
   always @(posedge clock_i) begin
      out_ready_i <= ($urandom_range(0, 3) != 0);
      if (!sys_rst_i && out_valid_o && out_ready_i) begin
         if (exp_q.size() == 0) check("extra word", 64'h0, 64'h1);
         else check("out word", exp_q.pop_front(),
                    {26'h0, out_sop_o, out_eop_o, out_be_o, out_data_o});
      end
      if (!sys_rst_i && tx_error_flag_o) n_err++;
      if (!sys_rst_i && buffer_loaded_flag_o) n_ld++;
   end

   // Main sequence
   initial begin
      errors = 0;
      comparisons = 0;
      exp_err = 0;
      exp_ld = 0;
      n_err = 0;
      n_ld = 0;
      tot = 0;
      ref_b = 32'h0;
      mask = 2'h0;
      sys_rst_i = 1'b1;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(88));
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      axi_rd(tbcc_pkg::REG_MASK, 32'h0, tbcc_pkg::RESP_OKAY);
      axi_rd(tbcc_pkg::REG_STATUS, 32'h0, tbcc_pkg::RESP_OKAY);
      axi_wr(4'h2, 32'h0000_0003, tbcc_pkg::RESP_SLVERR);
      axi_rd(4'h6, 32'h0, tbcc_pkg::RESP_SLVERR);
      axi_rd(tbcc_pkg::REG_MASK, 32'h0, tbcc_pkg::RESP_OKAY);
      // Sizes exclude offset and padding
      run_buf(0, 4, 0, 1, 1, 1, 4, 1);
      run_buf(31, 1, 1, 1, 1, 1, 1, 2);
      run_buf(3, 33, 2, 1, 1, 0, 33, 3);
      run_buf(2, 5, 3, 1, 1, 1, 5, 4);
      run_buf(1, 6, 0, 1, 0, 0, 15, 5);
      run_buf(0, 4, 1, 0, 0, 1, 15, 5);
      run_buf(3, 5, 2, 0, 1, 1, 15, 5);
      run_buf(0, 8, 0, 1, 0, 0, 10, 6);
      run_buf(0, 2, 0, 0, 1, 0, 10, 7);
      run_buf(0, 7, 0, 1, 1, 1, 9, 8);
      run_buf(5, 0, 1, 1, 1, 1, 0, 9);
      run_buf(0, 0, 0, 1, 1, 1, 0, 10);
      for (i = 0; i < 12; i++) begin
         o = $urandom_range(0, 31);
         s = $urandom_range(0, 40);
         run_buf(o, s, $urandom_range(0, 3), 1, 1, $urandom_range(0, 1), s, i);
      end
      for (i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clock_i);
      check("words left", 64'h0, 64'(exp_q.size()));
      results();
   end
endmodule
